// >>> rtl/acc_slice.sv
/*
 acc_slice: one combinational slice of the accumulator, an adder with
 carry in and carry out. Assumes the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
module acc_slice
   import servo_pkg::*;
#(
   parameter int W = SLICE_W
) (
   input  wire logic [W-1:0] a_in,
   input  wire logic [W-1:0] b_in,
   input  wire logic         carry_in,
   output logic      [W-1:0] sum_out,
   output logic              carry_out
);
   logic [W:0] full;

   always_comb begin
      full      = {1'b0, a_in} + {1'b0, b_in} + {{W{1'b0}}, carry_in};
      sum_out   = full[W-1:0];
      carry_out = full[W];
   end
endmodule
`default_nettype wire

// >>> rtl/servo_error_accumulator.sv
/*
 servo_error_accumulator: 24-bit target accumulator and proportional error
 former, built from three 8-bit slices. Assumes load strobes, step data and
 position data are synchronous to clock_in; strobes are one-cycle enables.
*/
// What this block does
// - three chained 8-bit slices make 24 bits
// - capture host target value, hold until replaced
// - output target minus present position as error
// - operand register loads on operand load clock
// - target register written only by target store
// - servo mode loads position counter into operand
// - command mode host step forms new target
// - operand load clock choice fixed before operation
// - servo mode inverts position, carry in one
// - target register starts at zero
// - sum registered on main clock before transfer
`timescale 1ns/1ps
`default_nettype none
module servo_error_accumulator
   import servo_pkg::*;
#(
   parameter load_sel_type OPERAND_LOAD_SEL = LOAD_ON_OPERAND_CLOCK
) (
   input  wire logic             clock_in,
   input  wire logic             rst_in,
   input  wire logic             clk_en_in,
   input  wire mode_type         mode_in,
   input  wire strobes_type      strobes_in,
   input  wire logic [POS_W-1:0] host_step_in,
   input  wire logic [POS_W-1:0] position_in,
   output logic      [POS_W-1:0] result_out,
   output logic      [POS_W-1:0] target_out,
   output logic                  carry_out,
   output logic                  result_valid_out
);
   logic [POS_W-1:0] operand_ff;
   logic             carry_in_ff;
   logic [POS_W-1:0] target_ff;
   logic [POS_W-1:0] result_ff;
   logic             carry_ff;
   logic             valid_ff;
   logic [SLICES:0]  chain;
   logic [POS_W-1:0] sum;
   logic             operand_strobe;
   logic [POS_W-1:0] nxt_operand;
   logic             nxt_carry_in;
   logic [POS_W:0]   wide_sum;

   // fixed at elaboration, never at run time
   assign operand_strobe = (OPERAND_LOAD_SEL == LOAD_ON_OPERAND_CLOCK) ?
                           strobes_in.operand_load : strobes_in.target_store;

   always_comb begin
      if (mode_in == MODE_SERVO) begin
         nxt_operand  = ~position_in;
         nxt_carry_in = CARRY_SUBTRACT;
      end else begin
         nxt_operand  = host_step_in;
         nxt_carry_in = CARRY_ADD;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         operand_ff  <= OPERAND_RESET;
         carry_in_ff <= CARRY_ADD;
      end else if (clk_en_in && operand_strobe) begin
         operand_ff  <= nxt_operand;
         carry_in_ff <= nxt_carry_in;
      end
   end

   assign chain[0] = carry_in_ff;

   // full-width reference sum, kept apart from the slice chain
   assign wide_sum = {1'b0, target_ff} + {1'b0, operand_ff} + {{POS_W{1'b0}}, carry_in_ff};

   generate
      for (genvar i = 0; i < SLICES; i++) begin : g_slice
         acc_slice #(.W(SLICE_W)) u_slice (
            .a_in      (target_ff[i*SLICE_W +: SLICE_W]),
            .b_in      (operand_ff[i*SLICE_W +: SLICE_W]),
            .carry_in  (chain[i]),
            .sum_out   (sum[i*SLICE_W +: SLICE_W]),
            .carry_out (chain[i+1])
         );
      end
   endgenerate

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         result_ff <= RESULT_RESET;
         carry_ff  <= 1'b0;
         valid_ff  <= 1'b0;
      end else if (clk_en_in) begin
         valid_ff <= strobes_in.compute;
         if (strobes_in.compute) begin
            result_ff <= sum;
            carry_ff  <= chain[SLICES];
         end
      end
   end

   // target only moves in command mode on a target store strobe
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         target_ff <= TARGET_RESET;
      end else if (clk_en_in && strobes_in.target_store
                   && mode_in == MODE_COMMAND) begin
         target_ff <= result_ff;
      end
   end

   assign result_out       = result_ff;
   assign target_out       = target_ff;
   assign carry_out        = carry_ff;
   assign result_valid_out = valid_ff;

   chk_target_store_only: assert property (@(posedge clock_in) disable iff (rst_in)
      !(clk_en_in && strobes_in.target_store && mode_in == MODE_COMMAND)
      |=> $stable(target_ff))
      else $error("target changed without a store");

   chk_target_takes_result: assert property (@(posedge clock_in) disable iff (rst_in)
      (clk_en_in && strobes_in.target_store && mode_in == MODE_COMMAND)
      |=> target_ff == $past(result_ff))
      else $error("target did not take result");

   chk_servo_operand_inverted: assert property (@(posedge clock_in) disable iff (rst_in)
      (clk_en_in && operand_strobe && mode_in == MODE_SERVO)
      |=> operand_ff == ~$past(position_in))
      else $error("servo operand not inverted position");

   chk_servo_carry_one: assert property (@(posedge clock_in) disable iff (rst_in)
      (clk_en_in && operand_strobe && mode_in == MODE_SERVO) |=> carry_in_ff)
      else $error("servo carry in not one");

   chk_command_operand_step: assert property (@(posedge clock_in) disable iff (rst_in)
      (clk_en_in && operand_strobe && mode_in == MODE_COMMAND)
      |=> operand_ff == $past(host_step_in) && !carry_in_ff)
      else $error("command operand not host step");

   chk_operand_hold: assert property (@(posedge clock_in) disable iff (rst_in)
      !(clk_en_in && operand_strobe) |=> $stable(operand_ff))
      else $error("operand changed without load");

   chk_result_sum: assert property (@(posedge clock_in) disable iff (rst_in)
      (clk_en_in && strobes_in.compute)
      |=> result_ff == POS_W'($past(target_ff) + $past(operand_ff)
                              + POS_W'($past(carry_in_ff))))
      else $error("result is not the registered sum");

   chk_servo_error: assert property (@(posedge clock_in) disable iff (rst_in)
      (clk_en_in && operand_strobe && mode_in == MODE_SERVO)
      ##1 (clk_en_in && strobes_in.compute && !operand_strobe
           && !strobes_in.target_store)
      |=> result_ff == POS_W'($past(target_ff, 2) - $past(position_in, 2)))
      else $error("error is not target minus position");

   chk_frozen_enable: assert property (@(posedge clock_in) disable iff (rst_in)
      !clk_en_in |=> $stable(result_ff) && $stable(target_ff) && $stable(operand_ff))
      else $error("state moved with enable low");

   // carry, valid and stored carry in freeze with the enable as well
   chk_frozen_flags: assert property (@(posedge clock_in) disable iff (rst_in)
      !clk_en_in |=> $stable(carry_ff) && $stable(valid_ff) && $stable(carry_in_ff))
      else $error("flags moved with enable low");

   // the three-slice chain must equal one full-width add
   chk_slices_match: assert property (@(posedge clock_in) disable iff (rst_in)
      {chain[SLICES], sum} == wide_sum)
      else $error("slice chain differs from full sum");

   chk_carry_registered: assert property (@(posedge clock_in) disable iff (rst_in)
      (clk_en_in && strobes_in.compute) |=> carry_ff == $past(wide_sum[POS_W]))
      else $error("carry out not captured with result");

   chk_valid_follows: assert property (@(posedge clock_in) disable iff (rst_in)
      clk_en_in |=> valid_ff == $past(strobes_in.compute))
      else $error("valid does not follow compute");

   chk_result_hold: assert property (@(posedge clock_in) disable iff (rst_in)
      (clk_en_in && !strobes_in.compute) |=> $stable(result_ff) && $stable(carry_ff))
      else $error("result changed without compute");

   chk_servo_target_kept: assert property (@(posedge clock_in) disable iff (rst_in)
      (clk_en_in && strobes_in.target_store && mode_in == MODE_SERVO)
      |=> $stable(target_ff))
      else $error("servo mode store moved the target");

   // default selection: the target store strobe must leave the operand alone
   chk_operand_select: assert property (@(posedge clock_in) disable iff (rst_in)
      (OPERAND_LOAD_SEL == LOAD_ON_OPERAND_CLOCK && clk_en_in && !strobes_in.operand_load)
      |=> $stable(operand_ff))
      else $error("operand loaded on the wrong strobe");

   // a store in the load cycle would move the target under the sum
   chk_command_new_target: assert property (@(posedge clock_in) disable iff (rst_in)
      (clk_en_in && operand_strobe && mode_in == MODE_COMMAND
       && !strobes_in.target_store)
      ##1 (clk_en_in && strobes_in.compute && !operand_strobe
           && !strobes_in.target_store)
      |=> result_ff == POS_W'($past(target_ff, 2) + $past(host_step_in, 2)))
      else $error("new target is not target plus step");

   cov_servo_compute: cover property (@(posedge clock_in) disable iff (rst_in)
      mode_in == MODE_SERVO && clk_en_in && strobes_in.compute);
   cov_target_update: cover property (@(posedge clock_in) disable iff (rst_in)
      mode_in == MODE_COMMAND && clk_en_in && strobes_in.target_store);
   cov_negative_step: cover property (@(posedge clock_in) disable iff (rst_in)
      mode_in == MODE_COMMAND && clk_en_in && operand_strobe
      && host_step_in[POS_W-1]);
   cov_frozen_compute: cover property (@(posedge clock_in) disable iff (rst_in)
      !clk_en_in && strobes_in.compute);
   cov_command_chain: cover property (@(posedge clock_in) disable iff (rst_in)
      (clk_en_in && strobes_in.compute) ##1 (clk_en_in && strobes_in.target_store));
endmodule
`default_nettype wire

// >>> rtl/servo_pkg.sv
/*
 servo_pkg: widths, reset values and carrier structs shared by the servo
 error accumulator and its 8-bit slice. Assumes a single synchronous clock.
*/
package servo_pkg;
   localparam int SLICE_W    = 8;
   localparam int SLICES     = 3;
   localparam int POS_W      = SLICE_W * SLICES;
   localparam logic [POS_W-1:0] TARGET_RESET = 24'h00_0000;
   localparam logic [POS_W-1:0] OPERAND_RESET = 24'h00_0000;
   localparam logic [POS_W-1:0] RESULT_RESET = 24'h00_0000;
   localparam logic CARRY_SUBTRACT = 1'b1;
   localparam logic CARRY_ADD      = 1'b0;

   typedef enum logic {
      MODE_COMMAND,
      MODE_SERVO
   } mode_type;

   typedef enum logic {
      LOAD_ON_OPERAND_CLOCK,
      LOAD_ON_TARGET_CLOCK
   } load_sel_type;

   typedef struct packed {
      logic             operand_load;
      logic             target_store;
      logic             compute;
   } strobes_type;

   typedef struct packed {
      logic [POS_W-1:0] result;
      logic             carry;
   } acc_type;
endpackage

// >>> sim/far_side_model.sv
/*
 far_side_model: host step bus and position counter sharing the operand
 lines. Assumes the bench supplies the values and the operating mode.
*/
`timescale 1ns/1ps
`default_nettype none
module far_side_model
   import servo_pkg::*;
(
   input  wire logic             clock_in,
   input  wire logic             rst_in,
   input  wire mode_type         mode_in,
   input  wire logic [POS_W-1:0] value_in,
   output logic      [POS_W-1:0] host_step_out,
   output logic      [POS_W-1:0] position_out
);
   logic [POS_W-1:0] step_ff;
   logic [POS_W-1:0] pos_ff;
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         step_ff <= '0;
         pos_ff  <= '0;
      end else if (mode_in == MODE_COMMAND) begin
         step_ff <= value_in;
      end else begin
         pos_ff <= value_in;
      end
   end
   // released side shows the inverse of its last value
   assign host_step_out = (mode_in == MODE_COMMAND) ? value_in : ~step_ff;
   assign position_out  = (mode_in == MODE_SERVO) ? value_in : ~pos_ff;
endmodule
`default_nettype wire

// >>> sim/testbench.sv
/*
 testbench: drives the servo error accumulator through the far side model.
 Assumes one 100 MHz clock and strobes given as one-cycle enables.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import servo_pkg::*;
   logic             clock_in;
   logic             rst_in;
   logic             clk_en_in;
   mode_type         mode_in;
   strobes_type      strobes_in;
   logic [POS_W-1:0] value;
   logic [POS_W-1:0] host_step;
   logic [POS_W-1:0] position;
   logic [POS_W-1:0] result_out;
   logic [POS_W-1:0] target_out;
   logic             carry_out;
   logic             result_valid_out;
   int               error_cnt = 0;
   int               cmp_count = 0;

   servo_error_accumulator dut_u (.clock_in(clock_in), .rst_in(rst_in),
      .clk_en_in(clk_en_in), .mode_in(mode_in), .strobes_in(strobes_in),
      .host_step_in(host_step), .position_in(position), .result_out(result_out),
      .target_out(target_out), .carry_out(carry_out),
      .result_valid_out(result_valid_out));
   far_side_model far_u (.clock_in(clock_in), .rst_in(rst_in), .mode_in(mode_in),
      .value_in(value), .host_step_out(host_step), .position_out(position));

   task automatic chk(input logic [POS_W-1:0] got, input logic [POS_W-1:0] exp,
                      input string msg);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   // operand load, compute, then store; checks result and target
   task automatic run_op(input mode_type m, input logic v, input logic [POS_W-1:0] d,
                         input logic [POS_W-1:0] res, input logic [POS_W-1:0] tgt);
      @(posedge clock_in);
      mode_in <= m;
      value <= d;
      strobes_in <= 3'h4;
      @(posedge clock_in);
      strobes_in <= 3'h1;
      @(posedge clock_in);
      strobes_in <= 3'h2;
      #1;
      chk(result_out, res, "result");
      chk({23'h00_0000, result_valid_out}, {23'h00_0000, v}, "valid");
      @(posedge clock_in);
      strobes_in <= 3'h0;
      #1;
      chk({23'h00_0000, result_valid_out}, 24'h00_0000, "valid pulse");
      chk(target_out, tgt, "target");
   endtask

   task automatic test_command;
      run_op(MODE_COMMAND, 1'b1, 24'h00_00FF, 24'h00_00FF, 24'h00_00FF);
      run_op(MODE_COMMAND, 1'b1, 24'h00_FF01, 24'h01_0000, 24'h01_0000);
      run_op(MODE_COMMAND, 1'b1, 24'hFF_0000, 24'h00_0000, 24'h00_0000);
      run_op(MODE_COMMAND, 1'b1, 24'h00_FFFF, 24'h00_FFFF, 24'h00_FFFF);
   endtask

   task automatic test_servo;
      run_op(MODE_SERVO, 1'b1, 24'h00_1000, 24'h00_EFFF, 24'h00_FFFF);
      chk({23'd0, carry_out}, 24'h00_0001, "carry");
      run_op(MODE_SERVO, 1'b1, 24'h01_0000, 24'hFF_FFFF, 24'h00_FFFF);
      chk({23'd0, carry_out}, 24'h00_0000, "borrow");
   endtask

   task automatic test_freeze;
      @(posedge clock_in);
      clk_en_in <= 1'b0;
      run_op(MODE_COMMAND, 1'b0, 24'h00_0001, 24'hFF_FFFF, 24'h00_FFFF);
      @(posedge clock_in);
      clk_en_in <= 1'b1;
   endtask

   task automatic print_verdict;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   initial begin
      #20000;
      error_cnt++;
      print_verdict();
   end

   initial begin
      rst_in = 1'b1;
      clk_en_in = 1'b1;
      mode_in = MODE_COMMAND;
      strobes_in = 3'b000;
      value = 24'h00_0000;
      repeat (6) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      #1;
      chk(target_out, TARGET_RESET, "target after reset");
      test_command();
      test_servo();
      test_freeze();
      print_verdict();
   end
endmodule
`default_nettype wire
